// file: hw/enc_img_defines.vh
`ifndef ENC_IMG_DEFINES_VH
`define ENC_IMG_DEFINES_VH
// ==========================================
// output image layout, bit positions in the 64-bit image
`define IMG_BITS 64
`define IMG_WDATA_LSB 0
`define IMG_RDADR_LSB 32
`define IMG_WADR_LSB 40
`define IMG_WREQ_BIT 47
`define IMG_CMPA_EN_BIT 48
`define IMG_CMPA_CLR_BIT 49
`define IMG_CMPB_EN_BIT 50
`define IMG_CMPB_CLR_BIT 51
`define IMG_HALT_BIT 56
// ==========================================
// internal register space
`define REG_ADDR_W 6
`define REG_DATA_W 32
`define REG_COUNT 64
`define REG_POS_IDX 6'h00
`define REG_CMPA_IDX 6'h01
`define REG_CMPB_IDX 6'h02
// ==========================================
// local software port, byte offsets
`define LOC_ADDR_W 4
`define LOC_CTRL 4'h0
`define LOC_STATUS 4'h4
`define LOC_POS 4'h8
`define CTRL_RESET 32'h00000000
`define CTRL_BADPAR_BIT 0
// ==========================================
// timing
`define CLK_PERIOD_NS 50
`define ENC_CYCLE_NS 100000
`define ENC_CYCLE_CYC (`ENC_CYCLE_NS / `CLK_PERIOD_NS)
`endif

// file: hw/output_image_decoder.v
// Operation
// - output image is eight bytes: value, read address, write address, compare, halt
// - four-byte write value is a 32-bit unsigned register value
// - read addresses 0 to 63, register contents returned in response data
// - selected register comes back in the very next response
// - write request 1 overwrites the addressed register with the write value once, until a request 0 clears the acknowledge
// - write request 0 writes nothing and clears the write acknowledge
// - write address selects one of 64 registers
// - comparator b clear bit at 1 holds its sticky flag reset
// - comparator a clear bit at 1 holds its sticky flag reset
// - comparator b disabled forces its three outputs to 0
// - comparator b enabled drives outputs from position versus its reference
// - comparator a disabled forces its three outputs to 0
// - comparator a enabled drives outputs from position versus its reference
// - halt bit 0 reads the encoder cyclically unless the parameter set is bad
// - halt bit 1 stops encoder communication until it returns to 0
// - sticky flag sets on equality and stays until its clear bit or its comparator is disabled
// - relation output 0 below reference, 1 at or above
// - halted status is 1 when halted or parameter set is bad
`timescale 1ns/1ps
`include "enc_img_defines.vh"

module output_image_decoder #(
  parameter ENC_CYCLE = `ENC_CYCLE_CYC
) (
  input wire CORE_CLK,
  input wire RST,
  // output image from the gateway, same clock domain
  input wire [`IMG_BITS-1:0] OUT_IMAGE,
  input wire OUT_IMAGE_STB,
  // encoder reader, same clock domain
  input wire [`REG_DATA_W-1:0] ENC_POS,
  input wire ENC_POS_STB,
  output reg ENC_READ_REQ,
  // response image
  output reg [`REG_DATA_W-1:0] IN_RD_DATA,
  output reg IN_IMAGE_STB,
  output reg IN_WRITE_ACK,
  output reg IN_HALTED,
  output wire IN_CMP_A_ABOVE,
  output wire IN_CMP_A_EQUAL,
  output wire IN_CMP_A_STICKY,
  output wire IN_CMP_B_ABOVE,
  output wire IN_CMP_B_EQUAL,
  output wire IN_CMP_B_STICKY,
  // local software port
  input wire [`LOC_ADDR_W-1:0] REG_ADDR,
  input wire [`REG_DATA_W-1:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  output reg [`REG_DATA_W-1:0] REG_RDATA
);
  localparam AW = `REG_ADDR_W;
  localparam DW = `REG_DATA_W;
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_WRITE = 4'h2;
  localparam [3:0] S_READ = 4'h4;
  localparam [3:0] S_SEND = 4'h8;
  localparam CW = 32;

  // local port address match
  function hit;
    input [`LOC_ADDR_W-1:0] a;
    input [`LOC_ADDR_W-1:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [DW-1:0] wdata_q;
  reg [AW-1:0] waddr_q;
  reg [AW-1:0] raddr_q;
  reg wreq_q;
  reg cmp_a_enable_q;
  reg cmp_a_flag_clear_q;
  reg cmp_b_enable_q;
  reg cmp_b_flag_clear_q;
  reg halt_q;
  reg [DW-1:0] ctrl_q;
  reg [DW-1:0] encoder_position_reg;
  reg [DW-1:0] cmp_a_reference_reg;
  reg [DW-1:0] cmp_b_reference_reg;
  reg [CW-1:0] cyc_cnt_q;
  wire [DW-1:0] bank_rdata;
  wire bank_we;
  wire bad_parameter_flag;
  wire halted;
  wire [1:0] cmp_en;
  wire [1:0] cmp_clr;
  wire [1:0] cmp_above;
  wire [1:0] cmp_equal;
  wire [1:0] cmp_sticky;
  wire [DW-1:0] cmp_ref [0:1];

  assign bad_parameter_flag = ctrl_q[`CTRL_BADPAR_BIT];
  assign halted = halt_q | bad_parameter_flag;

  // ==========================================
  // telegram capture
  // image split into value, read address, write address, write request, compare and halt fields
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      wdata_q <= 32'h00000000;
      waddr_q <= 6'h00;
      raddr_q <= 6'h00;
      wreq_q <= 1'b0;
      cmp_a_enable_q <= 1'b0;
      cmp_a_flag_clear_q <= 1'b0;
      cmp_b_enable_q <= 1'b0;
      cmp_b_flag_clear_q <= 1'b0;
      halt_q <= 1'b0;
    end else if (OUT_IMAGE_STB && state_q == S_IDLE) begin
      wdata_q <= OUT_IMAGE[`IMG_WDATA_LSB +: DW];
      raddr_q <= OUT_IMAGE[`IMG_RDADR_LSB +: AW];
      waddr_q <= OUT_IMAGE[`IMG_WADR_LSB +: AW];
      wreq_q <= OUT_IMAGE[`IMG_WREQ_BIT];
      cmp_a_enable_q <= OUT_IMAGE[`IMG_CMPA_EN_BIT];
      cmp_a_flag_clear_q <= OUT_IMAGE[`IMG_CMPA_CLR_BIT];
      cmp_b_enable_q <= OUT_IMAGE[`IMG_CMPB_EN_BIT];
      cmp_b_flag_clear_q <= OUT_IMAGE[`IMG_CMPB_CLR_BIT];
      halt_q <= OUT_IMAGE[`IMG_HALT_BIT];
    end
  end

  // ==========================================
  // response sequencer
  // next state: capture, write, read, send
  always @* begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (OUT_IMAGE_STB) begin
          state_d = S_WRITE;
        end
      end
      S_WRITE: state_d = S_READ;
      S_READ: state_d = S_SEND;
      S_SEND: state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  // state register
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state_q <= S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // one write per request assertion, only while not yet acknowledged
  assign bank_we = (state_q == S_WRITE) && wreq_q && !IN_WRITE_ACK;

  // write acknowledge follows the request
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      IN_WRITE_ACK <= 1'b0;
    end else if (state_q == S_WRITE) begin
      if (wreq_q) begin
        IN_WRITE_ACK <= 1'b1;
      end else begin
        IN_WRITE_ACK <= 1'b0;
      end
    end
  end

  // ==========================================
  // register bank and mirrored registers
  reg_bank #(
    .AW(AW),
    .DW(DW),
    .DEPTH(`REG_COUNT)
  ) u_bank (
    .clk(CORE_CLK),
    .we(bank_we),
    .waddr(waddr_q),
    .wdata(wdata_q),
    .raddr(raddr_q),
    .rdata(bank_rdata)
  );

  // comparator references mirror writes to their addresses
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cmp_a_reference_reg <= 32'h00000000;
      cmp_b_reference_reg <= 32'h00000000;
    end else if (bank_we) begin
      if (waddr_q == `REG_CMPA_IDX) begin
        cmp_a_reference_reg <= wdata_q;
      end
      if (waddr_q == `REG_CMPB_IDX) begin
        cmp_b_reference_reg <= wdata_q;
      end
    end
  end

  // response: read data of this telegram's read address
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      IN_RD_DATA <= 32'h00000000;
      IN_IMAGE_STB <= 1'b0;
      IN_HALTED <= 1'b0;
    end else begin
      IN_IMAGE_STB <= (state_q == S_SEND);
      IN_HALTED <= halted;
      if (state_q == S_SEND) begin
        case (raddr_q)
          `REG_POS_IDX: IN_RD_DATA <= encoder_position_reg;
          `REG_CMPA_IDX: IN_RD_DATA <= cmp_a_reference_reg;
          `REG_CMPB_IDX: IN_RD_DATA <= cmp_b_reference_reg;
          default: IN_RD_DATA <= bank_rdata;
        endcase
      end
    end
  end

  // ==========================================
  // encoder cycle
  // read request pulse every cycle period while running
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cyc_cnt_q <= 32'h00000000;
      ENC_READ_REQ <= 1'b0;
    end else if (halted) begin
      cyc_cnt_q <= 32'h00000000;
      ENC_READ_REQ <= 1'b0;
    end else if (cyc_cnt_q == ENC_CYCLE - 1) begin
      cyc_cnt_q <= 32'h00000000;
      ENC_READ_REQ <= 1'b1;
    end else begin
      cyc_cnt_q <= cyc_cnt_q + 32'h00000001;
      ENC_READ_REQ <= 1'b0;
    end
  end

  // position latched from the reader, frozen while halted
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      encoder_position_reg <= 32'h00000000;
    end else if (ENC_POS_STB && !halted) begin
      encoder_position_reg <= ENC_POS;
    end
  end

  // ==========================================
  // comparators
  assign cmp_en = {cmp_b_enable_q, cmp_a_enable_q};
  assign cmp_clr = {cmp_b_flag_clear_q, cmp_a_flag_clear_q};
  assign cmp_ref[0] = cmp_a_reference_reg;
  assign cmp_ref[1] = cmp_b_reference_reg;

  // index 0 is comparator a, index 1 is comparator b
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_cmp
      pos_comparator #(
        .DW(DW)
      ) u_cmp (
        .clk(CORE_CLK),
        .rst(RST),
        .enable(cmp_en[gi]),
        .flag_clear(cmp_clr[gi]),
        .position(encoder_position_reg),
        .reference(cmp_ref[gi]),
        .at_or_above(cmp_above[gi]),
        .equal(cmp_equal[gi]),
        .sticky_match(cmp_sticky[gi])
      );
    end
  endgenerate

  assign IN_CMP_A_ABOVE = cmp_above[0];
  assign IN_CMP_A_EQUAL = cmp_equal[0];
  assign IN_CMP_A_STICKY = cmp_sticky[0];
  assign IN_CMP_B_ABOVE = cmp_above[1];
  assign IN_CMP_B_EQUAL = cmp_equal[1];
  assign IN_CMP_B_STICKY = cmp_sticky[1];

  // ==========================================
  // local software port
  // control register write
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ctrl_q <= `CTRL_RESET;
    end else if (REG_WR && hit(REG_ADDR, `LOC_CTRL)) begin
      ctrl_q <= {31'h00000000, REG_WDATA[`CTRL_BADPAR_BIT]};
    end
  end

  // read data one cycle after the strobe, zero when unmapped
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= 32'h00000000;
    end else if (REG_RD) begin
      if (hit(REG_ADDR, `LOC_CTRL)) begin
        REG_RDATA <= ctrl_q;
      end else if (hit(REG_ADDR, `LOC_STATUS)) begin
        REG_RDATA <= {24'h000000, halted, IN_WRITE_ACK, cmp_sticky, cmp_equal, cmp_above};
      end else if (hit(REG_ADDR, `LOC_POS)) begin
        REG_RDATA <= encoder_position_reg;
      end else begin
        REG_RDATA <= 32'h00000000;
      end
    end else begin
      REG_RDATA <= 32'h00000000;
    end
  end
endmodule // output_image_decoder

// file: hw/pos_comparator.v
`timescale 1ns/1ps
`include "enc_img_defines.vh"

// ==========================================
// position comparator with sticky match
module pos_comparator #(
  parameter DW = `REG_DATA_W
) (
  input wire clk,
  input wire rst,
  input wire enable,
  input wire flag_clear,
  input wire [DW-1:0] position,
  input wire [DW-1:0] reference,
  output reg at_or_above,
  output reg equal,
  output reg sticky_match
);
  wire eq = (position == reference);
  wire ge = (position >= reference);

  // disabled comparator reads all zero; clear holds the flag low
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      at_or_above <= 1'b0;
      equal <= 1'b0;
      sticky_match <= 1'b0;
    end else if (!enable) begin
      at_or_above <= 1'b0;
      equal <= 1'b0;
      sticky_match <= 1'b0;
    end else begin
      at_or_above <= ge;
      equal <= eq;
      if (flag_clear) begin
        sticky_match <= 1'b0;
      end else if (eq) begin
        sticky_match <= 1'b1;
      end
    end
  end
endmodule // pos_comparator

// file: hw/reg_bank.v
`timescale 1ns/1ps
`include "enc_img_defines.vh"

// ==========================================
// register bank
module reg_bank #(
  parameter AW = `REG_ADDR_W,
  parameter DW = `REG_DATA_W,
  parameter DEPTH = `REG_COUNT
) (
  input wire clk,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:DEPTH-1];

  // write port, registered read port (old data on same-edge collision)
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // reg_bank

// file: verif/enc_img_properties.sv
`timescale 1ns/1ps
`include "enc_img_defines.vh"
// ==========================================
// port checker for the image decoder
module enc_img_properties #(
  parameter ENC_CYCLE = `ENC_CYCLE_CYC
) (
  input wire CORE_CLK,
  input wire RST,
  input wire [`IMG_BITS-1:0] OUT_IMAGE,
  input wire OUT_IMAGE_STB,
  input wire ENC_READ_REQ,
  input wire IN_IMAGE_STB,
  input wire IN_WRITE_ACK,
  input wire IN_HALTED,
  input wire IN_CMP_A_ABOVE,
  input wire IN_CMP_A_EQUAL,
  input wire IN_CMP_A_STICKY,
  input wire IN_CMP_B_ABOVE,
  input wire IN_CMP_B_EQUAL,
  input wire IN_CMP_B_STICKY,
  input wire REG_RD,
  input wire [`REG_DATA_W-1:0] REG_RDATA
);
  reg [1:0] busy_q;
  reg [3:0] ctl_q;
  reg [15:0] gap_q;
  wire acc = OUT_IMAGE_STB && (busy_q == 2'h0);
  // accepted images, captured comparator controls, cycles since last read
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      busy_q <= 2'h0;
      ctl_q <= 4'h0;
      gap_q <= 16'h0;
    end else begin
      busy_q <= acc ? 2'h3 : ((busy_q != 2'h0) ? busy_q - 2'h1 : 2'h0);
      ctl_q <= acc ? OUT_IMAGE[51:48] : ctl_q;
      gap_q <= (IN_HALTED || ENC_READ_REQ) ? 16'h0 : gap_q + 16'h1;
    end
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  a_resp_four_late: assert property (acc |-> ##4 IN_IMAGE_STB)
    else $error("response strobe not four edges after image");
  a_resp_one_cycle: assert property (IN_IMAGE_STB |=> !IN_IMAGE_STB)
    else $error("response strobe longer than one cycle");
  a_ack_on_req: assert property (acc && OUT_IMAGE[`IMG_WREQ_BIT] |-> ##2 IN_WRITE_ACK)
    else $error("write ack missing");
  a_ack_cleared: assert property (acc && !OUT_IMAGE[`IMG_WREQ_BIT] |-> ##2 !IN_WRITE_ACK)
    else $error("write ack not cleared");
  a_halt_shown: assert property (acc && OUT_IMAGE[`IMG_HALT_BIT] |-> ##2 IN_HALTED)
    else $error("halted status missing");
  a_halt_quiet: assert property (IN_HALTED && $past(IN_HALTED) |-> !ENC_READ_REQ)
    else $error("encoder read while halted");
  a_read_cyclic: assert property (gap_q <= ENC_CYCLE + 2)
    else $error("encoder read overdue");
  a_cmp_a_off: assert property (!ctl_q[0] && !$past(ctl_q[0]) |->
    !(IN_CMP_A_ABOVE || IN_CMP_A_EQUAL || IN_CMP_A_STICKY))
    else $error("comparator a active while disabled");
  a_cmp_b_off: assert property (!ctl_q[2] && !$past(ctl_q[2]) |->
    !(IN_CMP_B_ABOVE || IN_CMP_B_EQUAL || IN_CMP_B_STICKY))
    else $error("comparator b active while disabled");
  a_sticky_a_kept: assert property ($fell(IN_CMP_A_STICKY) |->
    $past(ctl_q[1]) || !$past(ctl_q[0]))
    else $error("sticky a dropped without clear");
  a_equal_a_above: assert property (IN_CMP_A_EQUAL |-> IN_CMP_A_ABOVE &&
    (IN_CMP_A_STICKY || ctl_q[1] || $past(ctl_q[1])))
    else $error("equal a without above or sticky");
  a_rdata_quiet: assert property (REG_RDATA != 32'h0 |-> $past(REG_RD))
    else $error("read data outside read cycle");
endmodule // enc_img_properties

bind output_image_decoder enc_img_properties #(.ENC_CYCLE(ENC_CYCLE)) u_props (
  .CORE_CLK, .RST, .OUT_IMAGE, .OUT_IMAGE_STB, .ENC_READ_REQ, .IN_IMAGE_STB,
  .IN_WRITE_ACK, .IN_HALTED, .IN_CMP_A_ABOVE, .IN_CMP_A_EQUAL, .IN_CMP_A_STICKY,
  .IN_CMP_B_ABOVE, .IN_CMP_B_EQUAL, .IN_CMP_B_STICKY, .REG_RD, .REG_RDATA
);

// file: verif/gw_model.sv
`timescale 1ns/1ps
// ==========================================
// gateway model: sends output images, collects responses
module gw_model (
  input wire CORE_CLK,
  input wire IN_IMAGE_STB,
  input wire [31:0] IN_RD_DATA,
  output reg [63:0] OUT_IMAGE,
  output reg OUT_IMAGE_STB,
  output integer n_late
);
  // idle until the first telegram
  initial begin
    OUT_IMAGE = 64'h0;
    OUT_IMAGE_STB = 1'b0;
    n_late = 0;
  end
  // one telegram, image held until its response arrives
  task xfer(input [63:0] img, output [31:0] rd);
    integer i;
    begin
      @(posedge CORE_CLK);
      OUT_IMAGE <= img; // whole eight-byte image
      OUT_IMAGE_STB <= 1'b1;
      @(posedge CORE_CLK);
      OUT_IMAGE_STB <= 1'b0; // request and value stay put
      i = 0;
      while (IN_IMAGE_STB !== 1'b1 && i < 10) begin
        @(posedge CORE_CLK);
        i = i + 1;
      end
      rd = IN_RD_DATA;
      if (i >= 10)
        n_late = n_late + 1;
      @(negedge CORE_CLK);
    end
  endtask
endmodule // gw_model

// file: verif/tb_encoder_output_image_decoder.sv
`timescale 1ns/1ps
`include "enc_img_defines.vh"
// ==========================================
// testbench
module tb_encoder_output_image_decoder;
  localparam CYC = 8;
  reg CORE_CLK;
  reg RST;
  reg [31:0] ENC_POS;
  reg ENC_POS_STB;
  reg [3:0] REG_ADDR;
  reg [31:0] REG_WDATA;
  reg REG_WR;
  reg REG_RD;
  wire [63:0] OUT_IMAGE;
  wire OUT_IMAGE_STB;
  wire ENC_READ_REQ;
  wire [31:0] IN_RD_DATA;
  wire IN_IMAGE_STB;
  wire IN_WRITE_ACK;
  wire IN_HALTED;
  wire [5:0] cmp;
  wire [31:0] REG_RDATA;
  integer num_errors, n_compared, n_late, n_req, cycles;
  reg [31:0] rd;

  output_image_decoder #(.ENC_CYCLE(CYC)) uut (
    .CORE_CLK(CORE_CLK), .RST(RST), .OUT_IMAGE(OUT_IMAGE), .OUT_IMAGE_STB(OUT_IMAGE_STB),
    .ENC_POS(ENC_POS), .ENC_POS_STB(ENC_POS_STB), .ENC_READ_REQ(ENC_READ_REQ),
    .IN_RD_DATA(IN_RD_DATA), .IN_IMAGE_STB(IN_IMAGE_STB), .IN_WRITE_ACK(IN_WRITE_ACK),
    .IN_HALTED(IN_HALTED), .IN_CMP_A_ABOVE(cmp[5]), .IN_CMP_A_EQUAL(cmp[4]),
    .IN_CMP_A_STICKY(cmp[3]), .IN_CMP_B_ABOVE(cmp[2]), .IN_CMP_B_EQUAL(cmp[1]),
    .IN_CMP_B_STICKY(cmp[0]), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA)
  );
  gw_model gw (
    .CORE_CLK(CORE_CLK), .IN_IMAGE_STB(IN_IMAGE_STB), .IN_RD_DATA(IN_RD_DATA),
    .OUT_IMAGE(OUT_IMAGE), .OUT_IMAGE_STB(OUT_IMAGE_STB), .n_late(n_late)
  );
  // 20 mhz clock
  initial begin
    CORE_CLK = 1'b0;
    forever #25 CORE_CLK = ~CORE_CLK;
  end
  // count encoder reads and cut a hang short
  always @(posedge CORE_CLK) begin
    cycles = cycles + 1;
    if (ENC_READ_REQ === 1'b1)
      n_req = n_req + 1;
    if (cycles == 2000) begin
      num_errors = num_errors + 1;
      summarize;
    end
  end
  // compare one result
  task chk(input string what, input [31:0] exp, input [31:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("mismatch %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // build an output image
  function [63:0] mk(input [31:0] v, input [5:0] ra, input [5:0] wa, input wr,
                     input [3:0] c, input h);
    begin
      mk = 64'h0;
      mk[`IMG_WDATA_LSB +: 32] = v;
      mk[`IMG_RDADR_LSB +: 6] = ra;
      mk[`IMG_WADR_LSB +: 6] = wa;
      mk[`IMG_WREQ_BIT] = wr;
      mk[`IMG_CMPA_EN_BIT +: 4] = c;
      mk[`IMG_HALT_BIT] = h;
    end
  endfunction
  // local port write and read
  task reg_wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge CORE_CLK);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
      @(posedge CORE_CLK);
      REG_WR <= 1'b0;
    end
  endtask
  task reg_rd(input [3:0] a, output [31:0] d);
    begin
      @(posedge CORE_CLK);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge CORE_CLK);
      REG_RD <= 1'b0;
      @(negedge CORE_CLK);
      d = REG_RDATA;
    end
  endtask
  // encoder reader hands over a new position
  task set_pos(input [31:0] p);
    begin
      @(posedge CORE_CLK);
      ENC_POS <= p;
      ENC_POS_STB <= 1'b1;
      @(posedge CORE_CLK);
      ENC_POS_STB <= 1'b0;
      repeat (3) @(posedge CORE_CLK);
      @(negedge CORE_CLK);
    end
  endtask
  // verdict
  task summarize;
    begin
      num_errors = num_errors + n_late;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
        $display("Regression OK");
      end else begin
        $display("Regression broken");
      end
      $finish;
    end
  endtask
  // main sequence
  initial begin
    RST = 1'b1;
    ENC_POS = 32'h0;
    ENC_POS_STB = 1'b0;
    REG_ADDR = 4'h0;
    REG_WDATA = 32'h0;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    num_errors = 0;
    n_compared = 0;
    n_req = 0;
    cycles = 0;
    repeat (6) @(posedge CORE_CLK);
    RST <= 1'b0;
    gw.xfer(mk(32'hc0de1234, 6'h05, 6'h05, 1'b1, 4'h0, 1'b0), rd);
    chk("rd", 32'hc0de1234, rd);
    chk("ack", 32'h1, {31'h0, IN_WRITE_ACK});
    reg_rd(`LOC_STATUS, rd);
    chk("status", 32'h40, rd);
    gw.xfer(mk(32'h11111111, 6'h05, 6'h05, 1'b1, 4'h0, 1'b0), rd);
    chk("rd", 32'hc0de1234, rd);
    gw.xfer(mk(32'h22222222, 6'h05, 6'h05, 1'b0, 4'h0, 1'b0), rd);
    chk("ack", 32'h0, {31'h0, IN_WRITE_ACK});
    chk("rd", 32'hc0de1234, rd);
    gw.xfer(mk(32'hffffffff, 6'h3f, 6'h3f, 1'b1, 4'h0, 1'b0), rd);
    chk("rd", 32'hffffffff, rd);
    gw.xfer(mk(32'h0, 6'h05, 6'h3f, 1'b0, 4'h0, 1'b0), rd);
    chk("rd", 32'hc0de1234, rd);
    $display("test image_registers done");
    gw.xfer(mk(32'h64, 6'h00, 6'h01, 1'b1, 4'h0, 1'b0), rd);
    gw.xfer(mk(32'h0, 6'h00, 6'h01, 1'b0, 4'h0, 1'b0), rd);
    gw.xfer(mk(32'hc8, 6'h00, 6'h02, 1'b1, 4'h0, 1'b0), rd);
    gw.xfer(mk(32'h0, 6'h00, 6'h02, 1'b0, 4'h0, 1'b0), rd);
    set_pos(32'h64);
    gw.xfer(mk(32'h0, 6'h00, 6'h00, 1'b0, 4'h5, 1'b0), rd);
    chk("cmp", 32'h38, {26'h0, cmp});
    set_pos(32'h96);
    chk("cmp", 32'h28, {26'h0, cmp});
    set_pos(32'hc8);
    chk("cmp", 32'h2f, {26'h0, cmp});
    gw.xfer(mk(32'h0, 6'h00, 6'h00, 1'b0, 4'h7, 1'b0), rd);
    chk("cmp", 32'h27, {26'h0, cmp});
    gw.xfer(mk(32'h0, 6'h00, 6'h00, 1'b0, 4'hd, 1'b0), rd);
    chk("cmp", 32'h26, {26'h0, cmp});
    gw.xfer(mk(32'h0, 6'h00, 6'h00, 1'b0, 4'h1, 1'b0), rd);
    chk("cmp", 32'h20, {26'h0, cmp});
    set_pos(32'h64);
    chk("cmp", 32'h38, {26'h0, cmp});
    reg_rd(`LOC_STATUS, rd);
    chk("status", 32'h15, rd);
    gw.xfer(mk(32'h0, 6'h00, 6'h00, 1'b0, 4'h0, 1'b0), rd);
    chk("cmp", 32'h0, {26'h0, cmp});
    chk("pos", 32'h64, rd);
    $display("test comparators done");
    gw.xfer(mk(32'h0, 6'h00, 6'h00, 1'b0, 4'h0, 1'b1), rd);
    n_req = 0;
    repeat (3 * CYC) @(posedge CORE_CLK);
    chk("halted", 32'h1, {31'h0, IN_HALTED});
    chk("reads", 32'h0, n_req);
    set_pos(32'h99);
    gw.xfer(mk(32'h0, 6'h00, 6'h00, 1'b0, 4'h0, 1'b0), rd);
    n_req = 0;
    repeat (16) @(posedge CORE_CLK);
    chk("halted", 32'h0, {31'h0, IN_HALTED});
    chk("reads", 32'h2, n_req);
    reg_rd(`LOC_CTRL, rd);
    chk("ctrl", `CTRL_RESET, rd);
    reg_wr(`LOC_CTRL, 32'h1);
    reg_rd(`LOC_STATUS, rd);
    chk("status", 32'h80, rd);
    chk("halted", 32'h1, {31'h0, IN_HALTED});
    reg_rd(`LOC_POS, rd);
    chk("pos", 32'h64, rd);
    reg_rd(4'hc, rd);
    chk("unmapped", 32'h0, rd);
    reg_wr(`LOC_CTRL, 32'h0);
    $display("test halt done");
    summarize;
  end
endmodule // tb_encoder_output_image_decoder
